// file: rtl/lscc_regs.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  LED sink current configuration block.
  Assumes inclusion by the block's single design file.
*/
`ifndef LSCC_REGS_VH
`define LSCC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LSCC_ADDR_RAMP_DOWN     8'h11
`define LSCC_ADDR_RAMP_UP       8'h12
`define LSCC_ADDR_SEL_LO        8'h13
`define LSCC_ADDR_SEL_HI        8'h14
`define LSCC_ADDR_FULL_SCALE    8'h15

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LSCC_HOLD_MSB           5
`define LSCC_HOLD_LSB           3
`define LSCC_FADE_MSB           2
`define LSCC_FADE_LSB           0
`define LSCC_CODE_MSB           2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LSCC_RST_FULL_SCALE     3'h7
`define LSCC_RST_SEL_LO         8'h00
`define LSCC_RST_SEL_HI         2'h0
`define LSCC_RST_RAMP_DOWN      6'h00
`define LSCC_RST_RAMP_UP        3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LSCC_PWM_HZ             32768
`define LSCC_BASE_DIV           16
`define LSCC_BASE_CYCLES        (`LSCC_PWM_HZ / `LSCC_BASE_DIV)

`endif

// file: rtl/lscc_top.v
/*
  Current-setting register bank with shutdown ramp sequencer for a ten-port
  LED sink. Registers are written and read over a simple byte port driven by
  the serial interface logic, which lives outside. Ramp timing counts a PWM
  clock tick that arrives from outside the clk_i domain and is synchronised.
*/
`timescale 1ns/1ps
`include "lscc_regs.vh"

module lscc_top #(
  parameter BASE_CYCLES = `LSCC_BASE_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        shutdown_req_i,
  input  wire        pwm_clk_i,
  output reg  [7:0]  rdata_o,
  output reg  [9:0]  port_full_o,
  output reg  [2:0]  full_scale_code_o,
  output reg  [2:0]  ramp_scale_o,
  output reg         hold_off_o,
  output reg         fade_off_o,
  output reg         ramp_up_o,
  output reg         shut_down_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam ST_RUN  = 5'b00001;
  localparam ST_HOLD = 5'b00010;
  localparam ST_FADE = 5'b00100;
  localparam ST_OFF  = 5'b01000;
  localparam ST_RISE = 5'b10000;

  reg  [7:0]  half_full_sel_ports_lo_q;
  reg  [1:0]  half_full_sel_ports_hi_q;
  reg  [2:0]  code_q;
  reg  [5:0]  ramp_down_q;
  reg  [2:0]  ramp_up_q;
  reg  [4:0]  state_q;
  reg  [2:0]  scale_q;
  reg  [23:0] cnt_q;
  reg  [23:0] step_len_q;
  reg         pwm_s1_q;
  reg         pwm_s2_q;
  reg         pwm_s3_q;
  wire        tick;
  wire        step_done;
  wire [2:0]  hold_code;
  wire [2:0]  fade_code;

  assign hold_code = ramp_down_q[`LSCC_HOLD_MSB:`LSCC_HOLD_LSB];
  assign fade_code = ramp_down_q[`LSCC_FADE_MSB:`LSCC_FADE_LSB];

  // --------------------------------------------------------------------
  // Time of a code: base doubled per step; divided over scale steps for fades and rises.
  // --------------------------------------------------------------------
  function [23:0] span;
    input [2:0] c;
    begin
      span = BASE_CYCLES[23:0] << (c - 3'h1);
    end
  endfunction

  // --------------------------------------------------------------------
  // PWM clock synchroniser
  // --------------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_s1_q <= 1'b0;
      pwm_s2_q <= 1'b0;
      pwm_s3_q <= 1'b0;
    end else begin
      pwm_s1_q <= pwm_clk_i;
      pwm_s2_q <= pwm_s1_q;
      pwm_s3_q <= pwm_s2_q;
    end
  end

  assign tick      = pwm_s2_q & ~pwm_s3_q;
  assign step_done = tick && (cnt_q + 24'h1 >= step_len_q);

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_full_sel_ports_lo_q <= `LSCC_RST_SEL_LO;
      half_full_sel_ports_hi_q <= `LSCC_RST_SEL_HI;
      code_q                   <= `LSCC_RST_FULL_SCALE;
      ramp_down_q              <= `LSCC_RST_RAMP_DOWN;
      ramp_up_q                <= `LSCC_RST_RAMP_UP;
    end else if (wr_i) begin
      if (addr_i == `LSCC_ADDR_SEL_LO) begin
        half_full_sel_ports_lo_q <= wdata_i;
      end else if (addr_i == `LSCC_ADDR_SEL_HI) begin
        half_full_sel_ports_hi_q <= wdata_i[1:0];
      end else if (addr_i == `LSCC_ADDR_FULL_SCALE) begin
        code_q <= wdata_i[`LSCC_CODE_MSB:0];
      end else if (addr_i == `LSCC_ADDR_RAMP_DOWN) begin
        ramp_down_q <= wdata_i[5:0];
      end else if (addr_i == `LSCC_ADDR_RAMP_UP) begin
        ramp_up_q <= wdata_i[2:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Read-back and outputs
  // --------------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o           <= 8'h00;
      port_full_o       <= 10'h000;
      full_scale_code_o <= `LSCC_RST_FULL_SCALE;
      ramp_scale_o      <= 3'h0;
      hold_off_o        <= 1'b0;
      fade_off_o        <= 1'b0;
      ramp_up_o         <= 1'b0;
      shut_down_o       <= 1'b0;
    end else begin
      if (rd_i) begin
        if (addr_i == `LSCC_ADDR_SEL_LO) begin
          rdata_o <= half_full_sel_ports_lo_q;
        end else if (addr_i == `LSCC_ADDR_SEL_HI) begin
          rdata_o <= {6'h00, half_full_sel_ports_hi_q};
        end else if (addr_i == `LSCC_ADDR_FULL_SCALE) begin
          rdata_o <= {5'h00, code_q};
        end else if (addr_i == `LSCC_ADDR_RAMP_DOWN) begin
          rdata_o <= {2'h0, ramp_down_q};
        end else if (addr_i == `LSCC_ADDR_RAMP_UP) begin
          rdata_o <= {5'h00, ramp_up_q};
        end else begin
          rdata_o <= 8'h00;
        end
      end
      port_full_o       <= {half_full_sel_ports_hi_q, half_full_sel_ports_lo_q};
      full_scale_code_o <= code_q;
      ramp_scale_o      <= (scale_q > code_q) ? code_q : scale_q;
      hold_off_o        <= (state_q == ST_HOLD);
      fade_off_o        <= (state_q == ST_FADE);
      ramp_up_o         <= (state_q == ST_RISE);
      shut_down_o       <= (state_q == ST_OFF);
    end
  end

  // --------------------------------------------------------------------
  // Shutdown sequencer
  // --------------------------------------------------------------------
  // Fades step the scale once per eighth of the programmed time, so the
  // whole sweep over eight levels takes the full time; the cap means a low
  // global code waits at the top before the current starts to fall.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= ST_RUN;
      scale_q    <= 3'h7;
      cnt_q      <= 24'h000000;
      step_len_q <= 24'h000001;
    end else begin
      if (tick) begin
        cnt_q <= step_done ? 24'h000000 : cnt_q + 24'h1;
      end
      case (state_q)
        ST_RUN: begin
          cnt_q <= 24'h000000;
          // full scale in run
          // A ramp-up cut short by a new request must not leave the outputs dimmed.
          scale_q <= 3'h7;
          if (shutdown_req_i) begin
            if (hold_code != 3'h0) begin
              state_q    <= ST_HOLD;
              step_len_q <= span(hold_code);
            end else if (fade_code != 3'h0) begin
              state_q    <= ST_FADE;
              step_len_q <= span(fade_code) >> 3;
            end else begin
              state_q <= ST_OFF;
              scale_q <= 3'h0;
            end
          end
        end
        ST_HOLD: begin
          scale_q <= 3'h7;
          if (step_done) begin
            if (fade_code != 3'h0) begin
              state_q    <= ST_FADE;
              step_len_q <= span(fade_code) >> 3;
            end else begin
              state_q <= ST_OFF;
              scale_q <= 3'h0;
            end
          end
        end
        ST_FADE: begin
          if (step_done) begin
            if (scale_q == 3'h0) begin
              state_q <= ST_OFF;
            end else begin
              scale_q <= scale_q - 3'h1;
            end
          end
        end
        ST_OFF: begin
          cnt_q <= 24'h000000;
          if (!shutdown_req_i) begin
            if (ramp_up_q != 3'h0) begin
              state_q    <= ST_RISE;
              step_len_q <= span(ramp_up_q) >> 3;
            end else begin
              state_q <= ST_RUN;
              scale_q <= 3'h7;
            end
          end
        end
        ST_RISE: begin
          if (shutdown_req_i) begin
            state_q <= ST_RUN;
          end else if (step_done) begin
            if (scale_q == 3'h7) begin
              state_q <= ST_RUN;
            end else begin
              scale_q <= scale_q + 3'h1;
            end
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

endmodule // lscc_top

// file: verification/lscc_top_sva.sv
/*
  Checker for the current select bank and the shutdown ramp sequencer.
  Assumes it is bound to lscc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module lscc_top_sva #(
  parameter BASE_CYCLES = 16
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire [9:0] port_full_o,
  input wire [2:0] full_scale_code_o,
  input wire [2:0] ramp_scale_o,
  input wire       hold_off_o,
  input wire       fade_off_o,
  input wire       ramp_up_o,
  input wire       shut_down_o
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sel_lo_write: assert property (wr_i && addr_i == 8'h13 |=> ##1
    port_full_o[7:0] == $past(wdata_i, 2)) else $error("low select write not applied");
  a_sel_hi_write: assert property (wr_i && addr_i == 8'h14 |=> ##1
    port_full_o[9:8] == $past(wdata_i[1:0], 2)) else $error("high select write not applied");
  a_code_write: assert property (wr_i && addr_i == 8'h15 |=> ##1
    full_scale_code_o == $past(wdata_i[2:0], 2)) else $error("code write not applied");
  a_hi_rd_zero: assert property (rd_i && addr_i == 8'h14 |=> rdata_o[7:2] == 6'h00)
    else $error("high select upper bits not zero");
  a_code_rd_zero: assert property (rd_i && addr_i == 8'h15 |=> rdata_o[7:3] == 5'h00)
    else $error("code upper bits not zero");
  a_down_rd_zero: assert property (rd_i && addr_i == 8'h11 |=> rdata_o[7:6] == 2'h0)
    else $error("ramp down upper bits not zero");
  a_up_rd_zero: assert property (rd_i && addr_i == 8'h12 |=> rdata_o[7:3] == 5'h00)
    else $error("ramp up upper bits not zero");
  a_hold_full: assert property (hold_off_o |-> ramp_scale_o == full_scale_code_o)
    else $error("scale not at cap during hold");
  a_fade_falls: assert property (fade_off_o |=> ramp_scale_o <= $past(ramp_scale_o))
    else $error("scale rose during fade");
  a_rise_climbs: assert property (ramp_up_o |=> ramp_scale_o >= $past(ramp_scale_o))
    else $error("scale fell during ramp up");
  a_off_zero: assert property (shut_down_o |-> ramp_scale_o == 3'h0)
    else $error("scale not zero in shutdown");
  a_one_phase: assert property ($onehot0({hold_off_o, fade_off_o, ramp_up_o, shut_down_o}))
    else $error("more than one phase flag high");

  c_hold: cover property ($rose(hold_off_o));
  c_fade: cover property ($rose(fade_off_o));
  c_off: cover property ($rose(shut_down_o));
  c_rise: cover property ($fell(ramp_up_o));
endmodule // lscc_top_sva

bind lscc_top lscc_top_sva #(.BASE_CYCLES(BASE_CYCLES)) u_sva (.clk_i, .rst_i, .wr_i, .rd_i,
  .addr_i, .wdata_i, .rdata_o, .port_full_o, .full_scale_code_o, .ramp_scale_o,
  .hold_off_o, .fade_off_o, .ramp_up_o, .shut_down_o);

// file: verification/lscc_pwm_src.sv
/*
  Model of the free-running PWM clock that the host side supplies.
  Assumes the design synchronises it, so its phase is unrelated to clk_i.
*/
`timescale 1ns/1ps
module lscc_pwm_src #(
  parameter HALF_NS = 50
) (
  output reg pwm_clk_o
);
  // clock never stops.
  // A fast tick keeps the ramp runs short; the design only counts edges.
  initial begin
    pwm_clk_o = 1'b0;
    #3;
    forever #HALF_NS pwm_clk_o = ~pwm_clk_o;
  end
endmodule // lscc_pwm_src

// file: verification/testbench.sv
/*
  Self-checking bench for lscc_top: register access and shutdown ramps.
  Assumes BASE_CYCLES of 16 and a PWM tick every ten clk_i cycles.
*/
`timescale 1ns/1ps
module testbench;
  reg        clk_i, rst_i, wr_i, rd_i, shutdown_req_i;
  reg  [7:0] addr_i, wdata_i;
  wire       pwm_clk_i, hold_off_o, fade_off_o, ramp_up_o, shut_down_o;
  wire [7:0] rdata_o;
  wire [9:0] port_full_o;
  wire [2:0] full_scale_code_o, ramp_scale_o;
  wire [3:0] fl = {shut_down_o, ramp_up_o, fade_off_o, hold_off_o};
  integer    err_total = 0, checks = 0, cyc = 0, n, i;

  lscc_top #(.BASE_CYCLES(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .shutdown_req_i(shutdown_req_i),
    .pwm_clk_i(pwm_clk_i), .rdata_o(rdata_o), .port_full_o(port_full_o),
    .full_scale_code_o(full_scale_code_o), .ramp_scale_o(ramp_scale_o),
    .hold_off_o(hold_off_o), .fade_off_o(fade_off_o), .ramp_up_o(ramp_up_o),
    .shut_down_o(shut_down_o));
  lscc_pwm_src u_pwm (.pwm_clk_o(pwm_clk_i));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task chk(input string nm, input [15:0] exp, input [15:0] seen);
    checks = checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk_i); wr_i = 1'b1; addr_i = a; wdata_i = d;
    @(negedge clk_i); wr_i = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(negedge clk_i); rd_i = 1'b1; addr_i = a;
    @(negedge clk_i); rd_i = 1'b0;
    chk("rdata", {8'h00, exp}, {8'h00, rdata_o});
  endtask
  // Leaves n holding the cycles waited, so phase lengths can be judged.
  task wait_flag(input integer k, input reg lvl);
    n = 0;
    while (fl[k] !== lvl && n < 3000) begin @(negedge clk_i); n = n + 1; end
    chk("phase flag", {15'h0, lvl}, {15'h0, fl[k]});
  endtask
  task wrap_up;
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin clk_i = 1'b0; forever #5 clk_i = ~clk_i; end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin err_total = err_total + 1; wrap_up; end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
    shutdown_req_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    rd(8'h15, 8'h07);
    chk("code out", 16'h7, {13'h0, full_scale_code_o});
    rd(8'h13, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h16, 8'h00);
    wr(8'h13, 8'ha5); @(negedge clk_i);
    chk("sel lo", 16'ha5, {8'h0, port_full_o[7:0]});
    wr(8'h14, 8'hff); @(negedge clk_i);
    chk("sel all", 16'h3a5, {6'h0, port_full_o});
    rd(8'h14, 8'h03);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h15, {5'h1f, i[2:0]}); @(negedge clk_i); @(negedge clk_i);
      chk("scale cap", {13'h0, i[2:0]}, {13'h0, ramp_scale_o});
      rd(8'h15, {5'h00, i[2:0]});
    end
    wr(8'h11, 8'hff); rd(8'h11, 8'h3f);
    wr(8'h12, 8'hff); rd(8'h12, 8'h07);
    wr(8'h11, 8'h09); wr(8'h12, 8'h01);
    shutdown_req_i = 1'b1;
    wait_flag(0, 1'b1);
    chk("hold scale", 16'h7, {13'h0, ramp_scale_o});
    wait_flag(0, 1'b0);
    chk("hold length", 16'h1, {15'h0, n >= 140 && n <= 180});
    wait_flag(1, 1'b0);
    chk("fade length", 16'h1, {15'h0, n >= 130 && n <= 180});
    wait_flag(3, 1'b1);
    chk("off scale", 16'h0, {13'h0, ramp_scale_o});
    wr(8'h13, 8'h5a); @(negedge clk_i);
    chk("sel in off", 16'h5a, {8'h0, port_full_o[7:0]});
    shutdown_req_i = 1'b0;
    wait_flag(2, 1'b1);
    wait_flag(2, 1'b0);
    chk("rise length", 16'h1, {15'h0, n >= 130 && n <= 180});
    @(negedge clk_i);
    chk("rise scale", 16'h7, {13'h0, ramp_scale_o});
    wr(8'h11, 8'h00); wr(8'h12, 8'h00);
    shutdown_req_i = 1'b1;
    wait_flag(3, 1'b1);
    chk("instant off", 16'h1, {15'h0, n < 20});
    shutdown_req_i = 1'b0;
    wait_flag(3, 1'b0);
    repeat (3) @(negedge clk_i);
    chk("instant on", 16'h7, {13'h0, ramp_scale_o});
    // Low code caps the fade; a request during ramp-up must restart from full.
    wr(8'h15, 8'h03); wr(8'h11, 8'h01); wr(8'h12, 8'h02);
    shutdown_req_i = 1'b1;
    wait_flag(1, 1'b1);
    chk("fade start", 16'h3, {13'h0, ramp_scale_o});
    repeat (40) @(negedge clk_i);
    chk("fade top", 16'h3, {13'h0, ramp_scale_o});
    wait_flag(3, 1'b1);
    shutdown_req_i = 1'b0;
    wait_flag(2, 1'b1);
    repeat (50) @(negedge clk_i);
    chk("rise part", 16'h1, {15'h0, ramp_scale_o < 3'h3});
    shutdown_req_i = 1'b1;
    wait_flag(1, 1'b1);
    chk("refade start", 16'h3, {13'h0, ramp_scale_o});
    // Reset in mid-fade brings back the defaults.
    rst_i = 1'b1;
    shutdown_req_i = 1'b0;
    @(negedge clk_i);
    chk("reset flags", 16'h0, {12'h0, fl});
    chk("reset code", 16'h7, {13'h0, full_scale_code_o});
    @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk("reset scale", 16'h7, {13'h0, ramp_scale_o});
    rd(8'h15, 8'h07);
    rd(8'h13, 8'h00);
    wrap_up;
  end
endmodule // testbench
